// >>> design/pfh_host.sv
// host controller for an asynchronous parallel nor flash
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RQ1: flash reads array after reset, no command
// RQ2: read drives ce, oe low, we high
// RQ3: address stable before chip select falls
// RQ4: page is 8 words, low bits in page
// RQ5: in-page access short, new page full
// RQ6: write drives ce, we low, oe high
// RQ7: short program uses two write cycles
// RQ8: erase targets sector, several, or whole
// RQ9: buffered program at most 16 words
// RQ10: elevated voltage enables short program, unprotect
// RQ11: elevated voltage only while accelerated programming; the host raises acc_hv whenever accel_req is set, in every state but reset
// RQ12: identification codes read on low byte
// RQ13: standby floats outputs with ce high
// RQ14: read after standby waits full access
// RQ15: program continues after chip select removed
// RQ16: stable address sleeps, data stays latched
// RQ17: reset pulse aborts, floats, returns array read
// RQ18: host reissues interrupted program or erase
// RQ19: byte mode uses low lines, dq15 is address
module pfh_host #(
  parameter int unsigned ACC_CYCLES = pfh_pkg::ACC_CYC,
  parameter int unsigned PACC_CYCLES = pfh_pkg::PACC_CYC,
  parameter int unsigned RP_CYCLES = pfh_pkg::RP_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire pfh_pkg::pfh_req_t req,
  input wire logic byte_mode,
  input wire logic accel_req,
  input wire logic flash_rst_req,
  output logic req_ready,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic wr_done,
  output logic reissue_needed,
  output pfh_pkg::pfh_ctl_t ctl,
  output logic [21:0] addr_o,
  output logic byte_n,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe_n
);
  pfh_pkg::pfh_state_t state_reg;
  logic [pfh_pkg::CNT_W-1:0] cnt_reg;
  logic page_open_reg;
  logic [19:0] page_reg;
  logic wr_busy_reg;
  logic [22:0] a_reg;
  logic rd_last;
  logic wr_last;
  logic rst_leave;

  // page key from full address
  function automatic logic [19:0] page_of(input logic [22:0] a);
    page_of = a[22:pfh_pkg::PAGE_BITS];
  endfunction

  // data sampled after the page or full wait with select and oe low
  assign rd_last = state_reg == pfh_pkg::PFH_RD &&
    cnt_reg == pfh_pkg::CNT_W'(page_open_reg ? PACC_CYCLES : ACC_CYCLES); // RQ5
  // write strobe low for the write pulse width, then raised
  assign wr_last = state_reg == pfh_pkg::PFH_WR &&
    cnt_reg == pfh_pkg::CNT_W'(pfh_pkg::WP_CYC); // RQ6
  assign rst_leave = cnt_reg >= pfh_pkg::CNT_W'(RP_CYCLES - 1) && !flash_rst_req;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= pfh_pkg::PFH_RESET;
      cnt_reg <= '0;
      page_open_reg <= 1'b0;
      page_reg <= '0;
      a_reg <= '0;
    end else if (clk_en) begin
      unique case (state_reg)
        pfh_pkg::PFH_RESET: begin
          // hold clear pulse at least its minimum width
          page_open_reg <= 1'b0; // RQ17
          if (rst_leave) begin
            state_reg <= pfh_pkg::PFH_REC;
            cnt_reg <= '0;
          end else if (cnt_reg < pfh_pkg::CNT_W'(RP_CYCLES - 1)) begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        pfh_pkg::PFH_IDLE: begin
          cnt_reg <= '0;
          if (flash_rst_req) begin
            state_reg <= pfh_pkg::PFH_RESET;
          end else if (req.rd) begin
            a_reg <= req.addr;
            state_reg <= pfh_pkg::PFH_RD;
            // same page while selected gets the short wait
            if (!(page_open_reg && page_of(req.addr) == page_reg)) begin // RQ5
              page_open_reg <= 1'b0;
            end
          end else if (req.wr) begin
            a_reg <= req.addr;
            state_reg <= pfh_pkg::PFH_WR;
            page_open_reg <= 1'b0;
          end else begin
            // deselect to standby closes page
            page_open_reg <= 1'b0; // RQ14
          end
        end
        pfh_pkg::PFH_RD: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (rd_last) begin
            state_reg <= pfh_pkg::PFH_IDLE; // RQ5
            page_open_reg <= 1'b1;
            page_reg <= page_of(a_reg); // RQ4
          end
        end
        pfh_pkg::PFH_WR: begin
          cnt_reg <= cnt_reg + 1'b1;
          // each program cycle is one bus write
          if (wr_last) begin // RQ7
            state_reg <= pfh_pkg::PFH_REC;
            cnt_reg <= '0;
          end
        end
        pfh_pkg::PFH_REC: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == pfh_pkg::CNT_W'(pfh_pkg::REC_CYC - 1)) begin
            state_reg <= pfh_pkg::PFH_IDLE;
            cnt_reg <= '0;
          end
        end
        default: state_reg <= pfh_pkg::PFH_RESET;
      endcase
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b0, acc_hv: 1'b0};
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_n <= '1;
      byte_n <= 1'b1;
    end else if (clk_en) begin
      byte_n <= !byte_mode;
      ctl.reset_n <= !(state_reg == pfh_pkg::PFH_RESET && !rst_leave) &&
        !(state_reg == pfh_pkg::PFH_IDLE && flash_rst_req); // RQ17
      // elevated voltage follows accel_req in every state but reset
      ctl.acc_hv <= accel_req && state_reg != pfh_pkg::PFH_RESET; // RQ11
      if (state_reg == pfh_pkg::PFH_IDLE && !flash_rst_req && (req.rd || req.wr)) begin
        // address set one cycle before select falls
        addr_o <= byte_mode ? req.addr[22:1] : req.addr[21:0]; // RQ3
        dq_o <= req.wr ? req.wdata : 16'h0000;
        dq_oe_n <= '1;
        if (byte_mode) begin
          dq_oe_n[15] <= 1'b0; // RQ19
          dq_o[15] <= req.addr[0];
        end
      end
      unique case (state_reg)
        pfh_pkg::PFH_RD: begin
          ctl.ce_n <= 1'b0; // RQ2
          ctl.oe_n <= 1'b0;
          ctl.we_n <= 1'b1;
        end
        pfh_pkg::PFH_WR: begin
          ctl.ce_n <= 1'b0; // RQ6
          ctl.oe_n <= 1'b1;
          ctl.we_n <= wr_last; // RQ7
          if (!byte_mode) begin
            dq_oe_n <= '0;
          end else begin
            dq_oe_n[7:0] <= '0;
          end
        end
        default: begin
          // keep select low between same page reads
          ctl.ce_n <= !(state_reg == pfh_pkg::PFH_IDLE && page_open_reg && req.rd);
          ctl.oe_n <= 1'b1;
          ctl.we_n <= 1'b1;
          if (state_reg != pfh_pkg::PFH_IDLE || !(req.rd || req.wr)) begin
            dq_oe_n <= '1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // user side answers
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= '0;
      wr_done <= 1'b0;
      reissue_needed <= 1'b0;
      wr_busy_reg <= 1'b0;
    end else if (clk_en) begin
      req_ready <= state_reg == pfh_pkg::PFH_IDLE && !(req.rd || req.wr) && !flash_rst_req;
      rd_valid <= 1'b0;
      wr_done <= 1'b0;
      if (rd_last) begin
        rd_valid <= 1'b1;
        // byte mode uses the low lines only
        rd_data <= byte_mode ? {8'h00, dq_i[7:0]} : dq_i; // RQ12
      end
      if (wr_last) begin
        wr_done <= 1'b1;
        wr_busy_reg <= 1'b1;
      end else if (req.rd && state_reg == pfh_pkg::PFH_IDLE) begin
        wr_busy_reg <= 1'b0;
      end
      // flag that a reset may have cut a program or erase
      if (state_reg == pfh_pkg::PFH_IDLE && flash_rst_req && wr_busy_reg) begin
        reissue_needed <= 1'b1; // RQ18
      end else if (state_reg == pfh_pkg::PFH_IDLE && req.wr) begin
        reissue_needed <= 1'b0;
      end
    end
  end

  a_rd_ctl: assert property (@(posedge clk) disable iff (!arst_n) // RQ2
    (ctl.ce_n == 1'b0 && ctl.oe_n == 1'b0) |-> ctl.we_n) else $error("read with we low");
  a_wr_ctl: assert property (@(posedge clk) disable iff (!arst_n) // RQ6
    (ctl.we_n == 1'b0) |-> (ctl.ce_n == 1'b0 && ctl.oe_n)) else $error("write with oe low");
  a_addr_hold: assert property (@(posedge clk) disable iff (!arst_n) // RQ3
    (clk_en && $fell(ctl.ce_n)) |-> $stable(addr_o)) else $error("address moved at select");
  a_rst_quiet: assert property (@(posedge clk) disable iff (!arst_n) // RQ17
    !ctl.reset_n |-> (ctl.we_n && ctl.oe_n)) else $error("strobe during reset");
  a_rd_answer: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
    (clk_en && state_reg == pfh_pkg::PFH_IDLE && req.rd && !flash_rst_req && !page_open_reg)
    |=> !rd_valid [*4]) else $error("read answered too early");
  a_byte_dq15: assert property (@(posedge clk) disable iff (!arst_n) // RQ19
    !byte_n |-> dq_oe_n[14:8] == 7'h7f) else $error("dq8-14 driven");
  a_rst_width: assert property (@(posedge clk) disable iff (!arst_n) // RQ17
    (clk_en && $fell(ctl.reset_n)) |=> !ctl.reset_n) else $error("clear pulse short");
  a_wr_pulse: assert property (@(posedge clk) disable iff (!arst_n) // RQ7
    (clk_en && $rose(ctl.we_n)) |-> ctl.ce_n == 1'b0) else $error("we rose after select");
endmodule
`default_nettype wire

// >>> design/pfh_pkg.sv
// package for the parallel flash host controller
package pfh_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  // timing figures in ns, plain defaults
  localparam int unsigned ADDRESS_ACCESS_TIME_NS = 90;
  localparam int unsigned PAGE_ACCESS_TIME_NS = 25;
  localparam int unsigned MIN_CLEAR_PULSE_WIDTH_NS = 500;
  localparam int unsigned WRITE_PULSE_NS = 35;
  localparam int unsigned RECOVER_NS = 50;
  // least times round up to whole cycles
  localparam int unsigned ACC_CYC = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PACC_CYC = (PAGE_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RP_CYC = (MIN_CLEAR_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WP_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned PAGE_BITS = 3;
  localparam int unsigned PAGE_WORDS = 8;
  localparam int unsigned BUF_WORDS = 16;
  // host requests
  typedef struct packed {
    logic rd;
    logic wr;
    logic [22:0] addr;
    logic [15:0] wdata;
  } pfh_req_t;
  // flash pin bundle
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic acc_hv;
  } pfh_ctl_t;
  typedef enum logic [2:0] {
    PFH_RESET, PFH_IDLE, PFH_RD, PFH_WR, PFH_REC
  } pfh_state_t;
endpackage

// >>> sim/pfh_flash_model.sv
// behavioural model of the flash device on the far side of the host
`timescale 1ns/100ps
`default_nettype none
module pfh_flash_model (
  input wire pfh_pkg::pfh_ctl_t ctl,
  input wire logic [21:0] addr,
  input wire logic byte_n,
  input wire logic [15:0] dq,
  output logic [15:0] dq_drv,
  output logic [15:0] dq_en
);
  logic [15:0] mem [int];
  logic [15:0] w;
  logic [18:0] page = '0;
  logic page_open = 1'b0;
  realtime t0 = 0;
  initial dq_drv = 16'h0;
  initial dq_en = 16'h0;
  always @(negedge ctl.ce_n) begin
    t0 = $realtime;
    page_open = 1'b0;
    page = addr[21:3];
  end
  always @(addr) begin
    page_open = !ctl.ce_n && addr[21:3] == page;
    page = addr[21:3];
    t0 = $realtime;
  end
  always @(posedge ctl.we_n) begin
    if (!ctl.ce_n && ctl.reset_n) begin
      mem[addr] = dq;
    end
  end
  // released lines toggle so a stale value never reads as good
  always #5 begin
    if (ctl.reset_n && !ctl.ce_n && !ctl.oe_n && ctl.we_n && $realtime - t0 >=
        (page_open ? pfh_pkg::PAGE_ACCESS_TIME_NS : pfh_pkg::ADDRESS_ACCESS_TIME_NS)) begin
      w = mem.exists(addr) ? mem[addr] : addr[15:0] ^ 16'h5a5a;
      dq_drv = byte_n ? w : {~dq_drv[15:8], dq[15] ? w[15:8] : w[7:0]};
      dq_en = byte_n ? 16'hffff : 16'h00ff;
    end else begin
      dq_drv = ~dq_drv;
      dq_en = 16'h0;
    end
  end
endmodule
`default_nettype wire

// >>> sim/parallel_flash_bus_operations_tb.sv
// testbench for the parallel flash host controller
`timescale 1ns/100ps
`default_nettype none
module parallel_flash_bus_operations_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b1;
  pfh_pkg::pfh_req_t req = '0;
  logic byte_mode = 1'b0;
  logic accel_req = 1'b0;
  logic flash_rst_req = 1'b0;
  logic req_ready, rd_valid, wr_done, reissue_needed, byte_n;
  logic [15:0] rd_data, dq_o, dq_oe_n, dq_i, fl_drv, fl_en, rd_q;
  logic [21:0] addr_o;
  pfh_pkg::pfh_ctl_t ctl;
  logic [15:0] ref_mem [int];
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  int rst_cyc = 0;
  logic [31:0] rng = 32'h66ec;
  logic acc_seen = 1'b0;
  bit hold_req = 1'b0;
  always #20 clk = ~clk;
  assign dq_i = (~dq_oe_n & dq_o) | (dq_oe_n & fl_drv);
  pfh_host #(.RP_CYCLES(2)) i_pfh_host (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .req(req), .byte_mode(byte_mode), .accel_req(accel_req), .flash_rst_req(flash_rst_req),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .wr_done(wr_done),
    .reissue_needed(reissue_needed), .ctl(ctl), .addr_o(addr_o), .byte_n(byte_n),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n(dq_oe_n));
  pfh_flash_model i_pfh_flash_model (.ctl(ctl), .addr(addr_o), .byte_n(byte_n), .dq(dq_i),
    .dq_drv(fl_drv), .dq_en(fl_en));
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [15:0] ref_word(int k);
    return ref_mem.exists(k) ? ref_mem[k] : k[15:0] ^ 16'h5a5a;
  endfunction
  task automatic check(logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one bus request held until its answer
  task automatic xfer(logic wr, logic [22:0] a, logic [15:0] d, output int lat);
    // a held read chains straight on, keeping the page open
    if (req.rd !== 1'b1) begin
      @(negedge clk);
      while (req_ready !== 1'b1) @(negedge clk);
    end
    req = '{rd: !wr, wr: wr, addr: a, wdata: d};
    if (wr) ref_mem[byte_mode ? a[22:1] : a[21:0]] = d;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (rd_valid !== 1'b1 && wr_done !== 1'b1);
    rd_q = rd_data;
    if (!hold_req) req = '0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  always @(negedge clk) begin
    if (!ctl.reset_n) rst_cyc++;
    if (!ctl.we_n && ctl.acc_hv) acc_seen = 1'b1;
    if (rd_valid) check(fl_en & ~dq_oe_n, 16'h0000);
  end
  initial begin
    int lat;
    logic [22:0] a;
    logic [15:0] w;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    check({14'h0, ctl.ce_n, &dq_oe_n}, 16'h3);
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      xfer(1'b0, {1'b0, rng[21:0]}, 16'h0, lat);
      check(rd_q, ref_word(rng[21:0]));
      check(16'(lat >= pfh_pkg::ACC_CYC + 2), 16'h1);
    end
    rng = xs(rng);
    for (int j = 0; j < 8; j++) begin
      a = {1'b0, rng[21:3], 3'(j ^ 5)};
      hold_req = j < 7;
      xfer(1'b0, a, 16'h0, lat);
      check(rd_q, ref_word(a[21:0]));
      if (j > 0) check(16'(lat <= pfh_pkg::PACC_CYC + 3), 16'h1);
    end
    accel_req = 1'b1;
    rng = xs(rng);
    xfer(1'b1, 23'h555, 16'h00a0, lat);
    xfer(1'b1, {1'b0, rng[21:0]}, rng[31:16], lat);
    accel_req = 1'b0;
    check(16'(acc_seen), 16'h1);
    xfer(1'b0, {1'b0, rng[21:0]}, 16'h0, lat);
    check(16'(ctl.acc_hv), 16'h0);
    check(rd_q, rng[31:16]);
    byte_mode = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      xfer(1'b0, rng[22:0], 16'h0, lat);
      w = ref_word(rng[22:1]);
      check(rd_q, {8'h00, rng[0] ? w[15:8] : w[7:0]});
      check(16'(byte_n), 16'h0);
    end
    byte_mode = 1'b0;
    for (int k = 0; k < pfh_pkg::BUF_WORDS; k++) begin
      rng = xs(rng);
      xfer(1'b1, 23'h300 + 23'(k), rng[15:0], lat);
    end
    for (int k = 0; k < pfh_pkg::BUF_WORDS; k++) begin
      xfer(1'b0, 23'h300 + 23'(k), 16'h0, lat);
      check(rd_q, ref_word(32'h300 + k));
    end
    xfer(1'b1, 23'h1234, 16'hbeef, lat);
    xfer(1'b1, 23'h2222, 16'h0f0f, lat);
    rst_cyc = 0;
    flash_rst_req = 1'b1;
    while (ctl.reset_n !== 1'b0) @(negedge clk);
    flash_rst_req = 1'b0;
    while (req_ready !== 1'b1) @(negedge clk);
    check(16'(rst_cyc >= 2), 16'h1);
    check(16'(reissue_needed), 16'h1);
    xfer(1'b0, 23'h1234, 16'h0, lat);
    check(rd_q, 16'hbeef);
    xfer(1'b1, 23'h0040, 16'h5aa5, lat);
    check(16'(reissue_needed), 16'h0);
    stop_test();
  end
endmodule
`default_nettype wire
